// [hw/output_latch_route.sv]
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "output_latch_route_params.svh"
module output_latch_route #(
	parameter int PULSE_LONG_CYCLES  = `PULSE_LONG_MS * `REF_CLK_KHZ,
	parameter int PULSE_SHORT_CYCLES = `PULSE_SHORT_MS * `REF_CLK_KHZ,
	parameter int RETRIP_CYCLES      = `RETRIP_OPERATE_MS * `REF_CLK_KHZ
) (
	input  wire logic                                REF_CLK,
	input  wire logic                                RESETN,
	input  wire logic [3:0]                          REG_ADDR,
	input  wire logic [7:0]                          REG_WDATA,
	input  wire logic                                REG_WR,
	input  wire logic                                REG_RD,
	output logic [7:0]                               REG_RDATA,
	input  wire output_latch_route_pkg::stage_inputs_type STAGES,
	input  wire logic [7:0]                          FAULT_CONDITION,
	input  wire logic [8:0]                          START_PHASES,
	input  wire logic                                CLEAR_PANEL,
	input  wire logic                                CLEAR_SERIAL,
	input  wire logic                                CLEAR_DIGITAL_PIN,
	output output_latch_route_pkg::contact_type      CONTACTS,
	output logic [7:0]                               INDICATION,
	output logic [8:0]                               PHASE_DISPLAY,
	output logic                                     IRQ
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0]                               output_function_switches;
	logic [7:0]                               indication_mode_switches;
	logic [3:0]                               irq_status;
	logic [3:0]                               irq_mask;
	logic                                     clear_sync1;
	logic                                     clear_sync2;
	logic                                     clear_any;
	logic [2:0]                               latched;
	logic [2:0]                               power_request;
	logic [2:0]                               power_stretch;
	logic [1:0]                               signal_request;
	logic [1:0]                               signal_stretch;
	logic [23:0]                              power_length;
	logic [23:0]                              signal_length;
	logic                                     retrip;
	logic [31:0]                              retrip_count;
	output_latch_route_pkg::retrip_state_type retrip_state;
	output_latch_route_pkg::contact_type      next_contacts;
	output_latch_route_pkg::event_type        events;
	logic                                     power_one_d;
	logic [7:0]                               indication_d;
	logic                                     warning_d;

	function automatic logic [7:0] checksum(input logic [7:0] sw);
		logic [7:0] sum;
		sum = 8'h00;
		for (int n = 0; n < 8; n++) begin
			if (sw[n])
				sum = sum + 8'(1 << n);
		end
		return sum;
	endfunction

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			output_function_switches <= `OUTPUT_FUNCTION_RESET;
			indication_mode_switches <= `INDICATION_MODE_RESET;
			irq_mask <= `IRQ_MASK_RESET;
		end else if (REG_WR) begin
			case (REG_ADDR)
				`OFS_OUTPUT_FUNCTION: output_function_switches <= REG_WDATA;
				`OFS_INDICATION_MODE: indication_mode_switches <= REG_WDATA;
				`OFS_IRQ_MASK:        irq_mask <= REG_WDATA[3:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN)
			REG_RDATA <= 8'h00;
		else if (REG_RD) begin
			case (REG_ADDR)
				`OFS_OUTPUT_FUNCTION:  REG_RDATA <= output_function_switches;
				`OFS_INDICATION_MODE:  REG_RDATA <= indication_mode_switches;
				`OFS_OUTPUT_CHECKSUM:
					REG_RDATA <= checksum(output_function_switches);
				`OFS_INDICATION_CHECK:
					REG_RDATA <= checksum(indication_mode_switches);
				`OFS_IRQ_STATUS:       REG_RDATA <= {4'h0, irq_status};
				`OFS_IRQ_MASK:         REG_RDATA <= {4'h0, irq_mask};
				`OFS_CONTACT_STATE:    REG_RDATA <= {3'h0, CONTACTS};
				`OFS_INDICATION_STATE: REG_RDATA <= INDICATION;
				default:               REG_RDATA <= 8'h00;
			endcase
		end else
			REG_RDATA <= 8'h00;
	end

	// ----------------------------------------
	// Clear requests
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			clear_sync1 <= 1'b0;
			clear_sync2 <= 1'b0;
		end else begin
			clear_sync1 <= CLEAR_DIGITAL_PIN;
			clear_sync2 <= clear_sync1;
		end
	end

	assign clear_any = CLEAR_PANEL | CLEAR_SERIAL | clear_sync2;

	// ----------------------------------------
	// Pulse lengths and routing
	// ----------------------------------------
	assign power_length = output_function_switches[`SW_POWER_SHORT] ?
		24'(PULSE_SHORT_CYCLES) : 24'(PULSE_LONG_CYCLES);
	assign signal_length = output_function_switches[`SW_SIGNAL_SHORT] ?
		24'(PULSE_SHORT_CYCLES) : 24'(PULSE_LONG_CYCLES);

	assign power_request[0] = STAGES.trip[0];
	assign power_request[1] = STAGES.trip[1] | retrip;
	assign power_request[2] = STAGES.trip[2] | (STAGES.restart_inhibit &
		~output_function_switches[`SW_INHIBIT_BLOCK]);
	assign signal_request[0] = STAGES.signal[0];
	assign signal_request[1] = STAGES.signal[1] | (STAGES.supervision_warning &
		output_function_switches[`SW_SUPERVISION_ROUTE]);

	// ----------------------------------------
	// Power and signal outputs
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_power
			always_ff @(posedge REF_CLK or negedge RESETN) begin
				if (!RESETN)
					latched[i] <= 1'b0;
				else
					latched[i] <= output_function_switches[`SW_LATCH_BASE + i] &
						(power_request[i] | (latched[i] & ~clear_any));
			end

			min_pulse u_power_pulse (
				.clk     (REF_CLK),
				.rst_n   (RESETN),
				.trigger (power_request[i]),
				.length  (power_length),
				.active  (power_stretch[i])
			);

			assign next_contacts.power[i] =
				output_function_switches[`SW_LATCH_BASE + i] ?
				(power_request[i] | latched[i]) :
				(power_request[i] | power_stretch[i]);
		end
		for (i = 0; i < 2; i++) begin : g_signal
			min_pulse u_signal_pulse (
				.clk     (REF_CLK),
				.rst_n   (RESETN),
				.trigger (signal_request[i]),
				.length  (signal_length),
				.active  (signal_stretch[i])
			);

			assign next_contacts.signal[i] = signal_request[i] | signal_stretch[i];
		end
	endgenerate

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN)
			CONTACTS <= '0;
		else
			CONTACTS <= next_contacts;
	end

	// ----------------------------------------
	// Breaker failure retrip
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			retrip_state <= output_latch_route_pkg::RETRIP_IDLE;
			retrip_count <= 32'h00000000;
			retrip <= 1'b0;
		end else if (!output_function_switches[`SW_RETRIP_ENABLE]) begin
			retrip_state <= output_latch_route_pkg::RETRIP_IDLE;
			retrip_count <= 32'h00000000;
			retrip <= 1'b0;
		end else begin
			case (retrip_state)
				output_latch_route_pkg::RETRIP_IDLE: begin
					retrip <= 1'b0;
					retrip_count <= 32'h00000000;
					if (power_request[0] && !power_one_d)
						retrip_state <= output_latch_route_pkg::RETRIP_TIMING;
				end
				output_latch_route_pkg::RETRIP_TIMING: begin
					if (!STAGES.fault_present)
						retrip_state <= output_latch_route_pkg::RETRIP_IDLE;
					else if (retrip_count >= 32'(RETRIP_CYCLES - 1)) begin
						retrip_state <= output_latch_route_pkg::RETRIP_ACTIVE;
						retrip <= 1'b1;
					end else
						retrip_count <= retrip_count + 32'h00000001;
				end
				output_latch_route_pkg::RETRIP_ACTIVE: begin
					if (!STAGES.fault_present) begin
						retrip_state <= output_latch_route_pkg::RETRIP_IDLE;
						retrip <= 1'b0;
					end
				end
				default: begin
					retrip_state <= output_latch_route_pkg::RETRIP_IDLE;
					retrip <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Indications and phase display
	// ----------------------------------------
	generate
		for (i = 0; i < 8; i++) begin : g_indication
			always_ff @(posedge REF_CLK or negedge RESETN) begin
				if (!RESETN)
					INDICATION[i] <= 1'b0;
				else
					INDICATION[i] <= FAULT_CONDITION[i] |
						(indication_mode_switches[i] & INDICATION[i] & ~clear_any);
			end
		end
		for (i = 0; i < 3; i++) begin : g_phase
			always_ff @(posedge REF_CLK or negedge RESETN) begin
				if (!RESETN)
					PHASE_DISPLAY[3*i +: 3] <= 3'h0;
				else if (FAULT_CONDITION[`IND_STARTUP + i])
					PHASE_DISPLAY[3*i +: 3] <= START_PHASES[3*i +: 3];
				else if (!(indication_mode_switches[`IND_STARTUP + i] &&
					INDICATION[`IND_STARTUP + i] && !clear_any))
					PHASE_DISPLAY[3*i +: 3] <= 3'h0;
			end
		end
	endgenerate

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			power_one_d <= 1'b0;
			indication_d <= 8'h00;
			warning_d <= 1'b0;
		end else begin
			power_one_d <= power_request[0];
			indication_d <= INDICATION;
			warning_d <= STAGES.supervision_warning;
		end
	end

	assign events.trip = |(next_contacts.power & ~CONTACTS.power);
	assign events.retrip = retrip & ~CONTACTS.power[1];
	assign events.indication = |(INDICATION & ~indication_d);
	assign events.supervision = STAGES.supervision_warning & ~warning_d;

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN)
			irq_status <= 4'h0;
		else if (REG_WR && REG_ADDR == `OFS_IRQ_STATUS)
			irq_status <= (irq_status & ~REG_WDATA[3:0]) | events;
		else
			irq_status <= irq_status | events;
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_status & irq_mask);
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);

	chk_unlatched_drop: assert property (
		(!output_function_switches[0] && !power_request[0] && !power_stretch[0])
		|=> !CONTACTS.power[0])
		else $error("unlatched power output did not drop");

	chk_latched_hold: assert property (
		(output_function_switches[0] && latched[0] && !clear_any)
		|=> latched[0])
		else $error("latched power output released without clear");

	chk_clear_release: assert property (
		(clear_any && !power_request[0]) |=> !latched[0])
		else $error("clear request did not release latch");

	chk_latch_override: assert property (
		(latched[0] && output_function_switches[0]) |=> CONTACTS.power[0])
		else $error("latched output not active");

	chk_retrip_disabled: assert property (
		!output_function_switches[`SW_RETRIP_ENABLE] |=> !retrip)
		else $error("retrip active while disabled");

	chk_retrip_drive: assert property (
		retrip |=> CONTACTS.power[1])
		else $error("retrip did not drive power output two");

	chk_inhibit_route: assert property (
		(!output_function_switches[`SW_INHIBIT_BLOCK] && STAGES.restart_inhibit)
		|=> CONTACTS.power[2])
		else $error("restart inhibit not on power output three");

	chk_warning_route: assert property (
		(output_function_switches[`SW_SUPERVISION_ROUTE] &&
		STAGES.supervision_warning) |=> CONTACTS.signal[1])
		else $error("supervision warning not on signal output two");

	chk_indication_self: assert property (
		(!indication_mode_switches[0] && !FAULT_CONDITION[0]) |=> !INDICATION[0])
		else $error("self clearing indication stayed on");

	chk_indication_latch: assert property (
		(indication_mode_switches[0] && INDICATION[0] && !clear_any)
		|=> INDICATION[0])
		else $error("latching indication dropped");

	chk_checksum_read: assert property (
		(REG_RD && REG_ADDR == `OFS_OUTPUT_CHECKSUM)
		|=> REG_RDATA == $past(output_function_switches))
		else $error("checksum read wrong");

	cov_retrip: cover property (
		retrip_state == output_latch_route_pkg::RETRIP_ACTIVE);
	cov_latched_clear: cover property (latched[0] ##1 clear_any ##1 !latched[0]);
	cov_indication_latch: cover property (
		indication_mode_switches[0] && INDICATION[0] && !FAULT_CONDITION[0]);
	cov_irq: cover property (IRQ);

endmodule // output_latch_route

// [hw/output_latch_route_params.svh]
`ifndef OUTPUT_LATCH_ROUTE_PARAMS_SVH
`define OUTPUT_LATCH_ROUTE_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_OUTPUT_FUNCTION   4'h0
`define OFS_INDICATION_MODE   4'h1
`define OFS_OUTPUT_CHECKSUM   4'h2
`define OFS_INDICATION_CHECK  4'h3
`define OFS_IRQ_STATUS        4'h4
`define OFS_IRQ_MASK          4'h5
`define OFS_CONTACT_STATE     4'h6
`define OFS_INDICATION_STATE  4'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OUTPUT_FUNCTION_RESET 8'h00
`define INDICATION_MODE_RESET 8'h00
`define IRQ_MASK_RESET        4'h0

// ----------------------------------------
// Output function switch fields
// ----------------------------------------
`define SW_LATCH_BASE         0
`define SW_SIGNAL_SHORT       3
`define SW_POWER_SHORT        4
`define SW_RETRIP_ENABLE      5
`define SW_INHIBIT_BLOCK      6
`define SW_SUPERVISION_ROUTE  7

// ----------------------------------------
// Indication fields
// ----------------------------------------
`define IND_THERMAL           0
`define IND_STARTUP           1
`define IND_HIGH_SET          2
`define IND_UNDERCURRENT      3
`define IND_EARTH_FAULT       4
`define IND_UNBALANCE         5
`define IND_THERMISTOR_A      6
`define IND_THERMISTOR_B      7

// ----------------------------------------
// Timing
// ----------------------------------------
`define REF_CLK_KHZ           25000
`define PULSE_LONG_MS         80
`define PULSE_SHORT_MS        40
`define RETRIP_OPERATE_MS     100

`endif

// [hw/output_latch_route_pkg.sv]
package output_latch_route_pkg;

	typedef struct packed {
		logic [2:0] trip;
		logic [1:0] signal;
		logic       restart_inhibit;
		logic       supervision_warning;
		logic       fault_present;
	} stage_inputs_type;

	typedef struct packed {
		logic [2:0] power;
		logic [1:0] signal;
	} contact_type;

	typedef struct packed {
		logic supervision;
		logic indication;
		logic retrip;
		logic trip;
	} event_type;

	typedef enum logic [1:0] {
		RETRIP_IDLE,
		RETRIP_TIMING,
		RETRIP_ACTIVE
	} retrip_state_type;

endpackage

// [hw/min_pulse.sv]
`timescale 1ns/1ns
module min_pulse (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        trigger,
	input  wire logic [23:0] length,
	output logic             active
);

	logic        trigger_d;
	logic [23:0] remaining;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			trigger_d <= 1'b0;
		else
			trigger_d <= trigger;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			remaining <= 24'h000000;
		else if (trigger && !trigger_d)
			remaining <= length;
		else if (remaining != 24'h000000)
			remaining <= remaining - 24'h000001;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			active <= 1'b0;
		else
			active <= trigger | (remaining > 24'h000001);
	end

	chk_pulse_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(active && remaining > 24'h000001) |=> active)
		else $error("pulse ended before its minimum length");

	chk_pulse_load: assert property (@(posedge clk) disable iff (!rst_n)
		(trigger && !trigger_d) |=> (remaining == $past(length) && active))
		else $error("pulse counter not loaded on activation");

endmodule // min_pulse

// [dv/stage_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Protection stage model
// ----------------------------------------
module stage_model (
	input  wire logic                                clk,
	output output_latch_route_pkg::stage_inputs_type stages,
	output logic [7:0]                               cond,
	output logic [8:0]                               phases
);
	initial begin
		stages = '0;
		cond = 8'h00;
		phases = 9'h000;
	end

	// ----------------------------------------
	// Levels change just after a clock edge
	// ----------------------------------------
	task automatic set_req(input logic [7:0] v);
		@(posedge clk);
		stages <= output_latch_route_pkg::stage_inputs_type'(v);
	endtask

	task automatic set_cond(input logic [7:0] f, input logic [8:0] p);
		@(posedge clk);
		cond <= f;
		phases <= p;
	endtask
endmodule // stage_model

// [dv/output_latch_route_tb.sv]
`timescale 1ns/1ns
module output_latch_route_tb;
	localparam int LONG   = 20;
	localparam int SHORT  = 10;
	localparam int RETRIP = 30;

	logic                                     REF_CLK;
	logic                                     RESETN;
	logic [3:0]                               REG_ADDR;
	logic [7:0]                               REG_WDATA;
	logic                                     REG_WR;
	logic                                     REG_RD;
	logic [7:0]                               REG_RDATA;
	output_latch_route_pkg::stage_inputs_type STAGES;
	logic [7:0]                               FAULT_CONDITION;
	logic [8:0]                               START_PHASES;
	logic                                     CLEAR_PANEL;
	logic                                     CLEAR_SERIAL;
	logic                                     CLEAR_DIGITAL_PIN;
	output_latch_route_pkg::contact_type      CONTACTS;
	logic [7:0]                               INDICATION;
	logic [8:0]                               PHASE_DISPLAY;
	logic                                     IRQ;
	logic [4:0]                               con;
	logic [8:0]                               ph;
	int                                       error_cnt = 0;
	int                                       num_checks = 0;
	int                                       cycles = 0;
	int                                       w;
	logic [7:0]                               sw [5] = '{8'h00, 8'h10,
		8'h00, 8'h08, 8'h10};
	int                                       ix [5] = '{2, 2, 0, 1, 3};
	int                                       hd [5] = '{1, 1, 1, 1, 40};
	int                                       ex [5] = '{LONG, SHORT, LONG,
		SHORT, 40};

	assign con = CONTACTS;

	output_latch_route #(
		.PULSE_LONG_CYCLES  (LONG),
		.PULSE_SHORT_CYCLES (SHORT),
		.RETRIP_CYCLES      (RETRIP)
	) dut (
		.REF_CLK           (REF_CLK),
		.RESETN            (RESETN),
		.REG_ADDR          (REG_ADDR),
		.REG_WDATA         (REG_WDATA),
		.REG_WR            (REG_WR),
		.REG_RD            (REG_RD),
		.REG_RDATA         (REG_RDATA),
		.STAGES            (STAGES),
		.FAULT_CONDITION   (FAULT_CONDITION),
		.START_PHASES      (START_PHASES),
		.CLEAR_PANEL       (CLEAR_PANEL),
		.CLEAR_SERIAL      (CLEAR_SERIAL),
		.CLEAR_DIGITAL_PIN (CLEAR_DIGITAL_PIN),
		.CONTACTS          (CONTACTS),
		.INDICATION        (INDICATION),
		.PHASE_DISPLAY     (PHASE_DISPLAY),
		.IRQ               (IRQ)
	);

	stage_model stg (
		.clk    (REF_CLK),
		.stages (STAGES),
		.cond   (FAULT_CONDITION),
		.phases (START_PHASES)
	);

	initial begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge REF_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t timeout", $time);
			tally_and_finish();
		end
	end

	task automatic chk(input logic [8:0] got, input logic [8:0] exp,
		input string msg);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg,
				got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp,
		input string msg);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		#1;
		chk({1'b0, REG_RDATA}, {1'b0, exp}, msg);
	endtask

	task automatic clr(input int src);
		@(posedge REF_CLK);
		case (src)
			0: CLEAR_PANEL <= 1'b1;
			1: CLEAR_SERIAL <= 1'b1;
			default: CLEAR_DIGITAL_PIN <= 1'b1;
		endcase
		@(posedge REF_CLK);
		{CLEAR_PANEL, CLEAR_SERIAL, CLEAR_DIGITAL_PIN} <= 3'b000;
	endtask

	// Request held for hold cycles, contact high cycles counted
	task automatic measure(input int idx, input int hold, output int n);
		n = 0;
		fork
			begin
				stg.set_req(8'h08 << idx);
				repeat (hold - 1) @(posedge REF_CLK);
				stg.set_req(8'h00);
			end
			repeat (150) begin
				@(posedge REF_CLK);
				#1;
				if (con[idx] === 1'b1) n++;
			end
		join
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		RESETN = 1'b0;
		REG_ADDR = 4'h0;
		REG_WDATA = 8'h00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		{CLEAR_PANEL, CLEAR_SERIAL, CLEAR_DIGITAL_PIN} = 3'b000;
		repeat (20) @(posedge REF_CLK);
		RESETN <= 1'b1;
		cyc(2);
		for (int a = 0; a < 6; a++) rd(4'(a), 8'h00, "reset value");
		wr(4'h9, 8'hFF);
		rd(4'h9, 8'h00, "unmapped");
		wr(4'h0, 8'hA5);
		rd(4'h0, 8'hA5, "switch rw");
		rd(4'h2, 8'hA5, "checksum one");
		wr(4'h1, 8'h3C);
		rd(4'h3, 8'h3C, "checksum two");
		wr(4'h2, 8'h55);
		rd(4'h2, 8'hA5, "read only");
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h00);
		stg.set_req(8'h20);
		stg.set_req(8'h00);
		cyc(3);
		rd(4'h4, 8'h01, "trip status");
		chk(IRQ, 1'b0, "irq masked");
		wr(4'h5, 8'h01);
		cyc(2);
		chk(IRQ, 1'b1, "irq unmasked");
		wr(4'h4, 8'h01);
		cyc(2);
		chk(IRQ, 1'b0, "irq cleared");
		rd(4'h4, 8'h00, "status cleared");
		wr(4'h5, 8'h00);
		cyc(LONG);
		for (int k = 0; k < 5; k++) begin
			wr(4'h0, sw[k]);
			measure(ix[k], hd[k], w);
			chk(w >= ex[k] && w <= ex[k] + 2, 9'h001, "width");
		end
		for (int i = 0; i < 3; i++) begin
			wr(4'h0, 8'h01 << i);
			stg.set_req(8'h20 << i);
			stg.set_req(8'h00);
			cyc(LONG + 10);
			chk(con[i + 2], 1'b1, "latched");
			rd(4'h6, 8'h04 << i, "contact state");
			clr(i);
			cyc(6);
			chk(con[i + 2], 1'b0, "released");
		end
		wr(4'h0, 8'h00);
		stg.set_req(8'h21);
		stg.set_req(8'h01);
		cyc(RETRIP + 10);
		chk(con[3], 1'b0, "retrip off");
		stg.set_req(8'h00);
		cyc(LONG + 5);
		wr(4'h4, 8'h0F);
		wr(4'h0, 8'h20);
		stg.set_req(8'h21);
		stg.set_req(8'h01);
		cyc(RETRIP - 4);
		chk(con[3], 1'b0, "retrip early");
		cyc(8);
		chk(con[3], 1'b1, "retrip");
		rd(4'h4, 8'h03, "retrip status");
		stg.set_req(8'h00);
		cyc(LONG + 5);
		wr(4'h0, 8'h00);
		stg.set_req(8'h04);
		cyc(3);
		chk(con[4], 1'b1, "inhibit routed");
		wr(4'h0, 8'h40);
		cyc(LONG + 5);
		chk(con[4], 1'b0, "inhibit blocked");
		stg.set_req(8'h02);
		cyc(3);
		chk(con[1], 1'b0, "warning unrouted");
		wr(4'h0, 8'h80);
		cyc(3);
		chk(con[1], 1'b1, "warning routed");
		rd(4'h4, 8'h0B, "warning status");
		wr(4'h4, 8'h0F);
		stg.set_req(8'h00);
		wr(4'h0, 8'h00);
		cyc(LONG + 5);
		for (int i = 0; i < 8; i++) begin
			for (int m = 0; m < 2; m++) begin
				ph = (m ? 9'h002 : 9'h005) << (3 * (i - 1));
				ph = (i >= 1 && i <= 3) ? ph : 9'h000;
				wr(4'h1, m ? 8'h01 << i : 8'h00);
				stg.set_cond(8'h01 << i, ph);
				cyc(3);
				chk(INDICATION, 8'h01 << i, "indication on");
				chk(PHASE_DISPLAY, ph, "phases");
				stg.set_cond(8'h00, 9'h000);
				cyc(3);
				chk(INDICATION, m ? 8'h01 << i : 8'h00, "after");
				chk(PHASE_DISPLAY, m ? ph : 9'h000, "phases held");
				clr(i % 3);
				cyc(4);
				chk(INDICATION, 8'h00, "indication clear");
			end
		end
		rd(4'h4, 8'h04, "indication status");
		wr(4'h0, 8'h01);
		stg.set_req(8'h20);
		stg.set_req(8'h00);
		cyc(3);
		chk(con[2], 1'b1, "latched before reset");
		@(posedge REF_CLK);
		RESETN <= 1'b0;
		cyc(3);
		chk(con, 9'h000, "contacts in reset");
		@(posedge REF_CLK);
		RESETN <= 1'b1;
		cyc(2);
		chk(con, 9'h000, "contacts after reset");
		rd(4'h0, 8'h00, "switches after reset");
		rd(4'h4, 8'h00, "status after reset");
		tally_and_finish();
	end
endmodule // output_latch_route_tb
